// *** src/lsfc_top.sv ***
// Screen format controller with its display data FIFO
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`include "lsfc_defines.svh"

module lsfc_fifo #(
	parameter int WIDTH = `LSFC_FIFO_WIDTH,
	parameter int DEPTH = `LSFC_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} lsfc_fifo_state_t;
	lsfc_fifo_state_t s;
	lsfc_fifo_state_t next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;
	logic empty;
	assign empty = s.wr == s.rd;
	assign full = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[s.rd[AW-1:0]];
	always_comb
	begin
		next_s = s;
		if (in_valid_i && !full)
			next_s.wr = s.wr + 1'b1;
		if (out_ready_i && !empty)
			next_s.rd = s.rd + 1'b1;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s <= '0;
		else
			s <= next_s;
		if (in_valid_i && !full)
			mem[s.wr[AW-1:0]] <= in_data_i;
	end
	fifo_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
		full && !(out_ready_i && !empty) |=> !in_ready_o)
		else $error("fifo accepted past full");
endmodule : lsfc_fifo

module lsfc_top #(
	parameter int FIFO_DEPTH = `LSFC_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic char_clk_i,
	input wire logic dual_screen_i,
	input wire logic graphic_select_i,
	input wire logic large_screen_select_i,
	input wire logic wide_select_i,
	input wire logic attribute_or_select_i,
	input wire logic easy_mode_i,
	input wire logic skew_select_low_i,
	input wire logic skew_select_high_i,
	input wire logic [15:0] memory_data_in_i,
	output logic [15:0] memory_address_out_o,
	output logic [4:0] raster_address_out_o,
	output logic line_latch_clock_o,
	output logic display_window_timing_o,
	output logic cursor_display_out_o,
	output logic pixel_shift_clock_o,
	output logic [7:0] lcd_data_o,
	input wire logic lcd_ready_i
);
	import lsfc_pkg::*;
	lsfc_state_t s;
	lsfc_state_t next_s;
	lsfc_fmt_t fmt;
	logic tick;
	logic wb_req;
	logic [4:0] mode_eff;
	logic [4:0] maxras_eff;
	logic [4:0] cs_eff;
	logic [4:0] ce_eff;
	logic [7:0] vwid_eff;
	logic [8:0] duty_eff;
	logic [4:0] sras_eff;
	logic [1:0] blink_sel;
	logic blink_ok;
	logic attr_blink;
	logic disp_now;
	logic latch_now;
	logic cur_now;
	logic [15:0] addr_now;
	logic win_skew;
	logic cur_skew;
	logic push;
	logic [17:0] push_data;
	logic [7:0] ch_byte;
	logic fifo_ready;
	logic fifo_valid;
	logic [17:0] fifo_data;
	logic pop;
	logic line_end;
	logic frame_end;

	assign tick = s.ck_sync[1] && s.ck_sync[2] && !s.ck_lvl;
	assign wb_req = wb_cyc_i && wb_stb_i && !s.ack;

	// Pin order: dual, graphic, large, wide, attr, easy, skew low, skew high
	always_comb
	begin
		mode_eff = (s.easy ? 5'h00 : s.mode) |
			{1'b0, s.fpins[1], s.fpins[3], 1'b0, s.fpins[4]};
		maxras_eff = s.easy ? `LSFC_EASY_MAXRAS : s.maxras;
		cs_eff = s.easy ? `LSFC_EASY_CSTART : s.cstart[4:0];
		ce_eff = s.easy ? `LSFC_EASY_CEND : s.cend;
		vwid_eff = s.easy ? s.hdisp : s.vwidth;
		duty_eff = !s.easy ? s.duty : (s.fpins[0] ?
			`LSFC_EASY_DUTY_DUAL : `LSFC_EASY_DUTY_SINGLE);
		sras_eff = s.easy ? 5'h00 : s.sras;
		// Graphic with attribute bit or large screen pin picks mode 1, with neither mode 2
		if (!mode_eff[`LSFC_MODE_GC])
			fmt = FMT_CHAR;
		else if (mode_eff[`LSFC_MODE_AT] || s.fpins[2])
			fmt = FMT_GRAPH1;
		else
			fmt = FMT_GRAPH2;
		blink_sel = s.easy ? `LSFC_BLINK_ON : s.cstart[6:5];
		unique case (blink_sel)
			`LSFC_BLINK_ON: blink_ok = 1'b1;
			`LSFC_BLINK_OFF: blink_ok = 1'b0;
			`LSFC_BLINK_32: blink_ok = s.frame[4];
			`LSFC_BLINK_64: blink_ok = s.frame[5];
		endcase
		attr_blink = mode_eff[`LSFC_MODE_BLE] && s.frame[5];
		disp_now = (s.hcnt < s.hdisp) && !mode_eff[`LSFC_MODE_OFF];
		latch_now = ({1'b0, s.hcnt} >= {1'b0, s.hdisp}) &&
			({1'b0, s.hcnt} < {1'b0, s.hdisp} + `LSFC_REFRESH_PER_LINE);
		addr_now = s.row_base + {8'h00, s.hcnt};
		cur_now = (fmt == FMT_CHAR) && disp_now && blink_ok &&
			(addr_now == s.caddr) &&
			(s.raster >= cs_eff) && (s.raster <= ce_eff);
		// Delay taps; both pins high keeps the last skew, so skew 3 never occurs
		unique case (s.skew)
			2'h1: win_skew = s.win_d[0];
			2'h2: win_skew = s.win_d[1];
			default: win_skew = disp_now;
		endcase
		unique case (s.skew)
			2'h1: cur_skew = s.cur_d[0];
			2'h2: cur_skew = s.cur_d[1];
			default: cur_skew = cur_now;
		endcase
	end

	// Character byte: font row on the low byte, attribute on the high one
	always_comb
	begin
		ch_byte = s.md_s3[7:0];
		if (!mode_eff[`LSFC_MODE_AT])
			ch_byte = s.md_s3[7:0] | s.md_s3[15:8];
		else
		begin
			if (s.md_s3[`LSFC_ATR_REV])
				ch_byte = ~ch_byte;
			if (s.md_s3[`LSFC_ATR_BLINK] && attr_blink)
				ch_byte = 8'h00;
			if (s.md_s3[`LSFC_ATR_CUR])
				ch_byte = ~ch_byte;
			if (s.md_s3[`LSFC_ATR_WHITE])
				ch_byte = 8'h00;
			if (s.md_s3[`LSFC_ATR_BLACK])
				ch_byte = 8'hFF;
		end
		// Bit 17 marks a 16-bit word, bit 16 a doubled byte
		if (fmt == FMT_CHAR)
			push_data = {1'b0, mode_eff[`LSFC_MODE_WIDE], 8'h00, ch_byte};
		else
			push_data = {2'b10, s.md_s3};
	end

	assign push = tick && win_skew;
	assign pop = fifo_valid && s.ob_left == 2'h0;
	assign line_end = tick && (s.hcnt >= s.htotal);
	assign frame_end = line_end && (s.line >= duty_eff);

	lsfc_fifo #(
		.WIDTH(`LSFC_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push),
		.in_ready_o(fifo_ready),
		.in_data_i(push_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_data)
	);

	always_comb
	begin
		next_s = s;
		next_s.ck_sync = {s.ck_sync[1:0], char_clk_i};
		if (s.ck_sync[1] == s.ck_sync[2])
			next_s.ck_lvl = s.ck_sync[2];
		next_s.pin_s1 = {skew_select_high_i, skew_select_low_i, easy_mode_i,
			attribute_or_select_i, wide_select_i, large_screen_select_i,
			graphic_select_i, dual_screen_i};
		next_s.pin_s2 = s.pin_s1;
		next_s.pin_s3 = s.pin_s2;
		for (int i = 0; i < 8; i++)
			if (s.pin_s2[i] == s.pin_s3[i])
				next_s.pins[i] = s.pin_s3[i];
		next_s.md_s1 = memory_data_in_i;
		next_s.md_s2 = s.md_s1;
		next_s.md_s3 = s.md_s2;

		next_s.ack = wb_req;
		next_s.rdat = 32'h0000_0000;
		if (wb_req && !wb_we_i)
			unique case (wb_adr_i)
				`LSFC_OFS_HTOTAL: next_s.rdat = {24'h00_0000, s.htotal};
				`LSFC_OFS_HDISP: next_s.rdat = {24'h00_0000, s.hdisp};
				`LSFC_OFS_MAXRAS: next_s.rdat = {27'h000_0000, s.maxras};
				`LSFC_OFS_CSTART: next_s.rdat = {25'h000_0000, s.cstart};
				`LSFC_OFS_CEND: next_s.rdat = {27'h000_0000, s.cend};
				`LSFC_OFS_SADDR: next_s.rdat = {16'h0000, s.saddr};
				`LSFC_OFS_CADDR: next_s.rdat = {16'h0000, s.caddr};
				`LSFC_OFS_VWIDTH: next_s.rdat = {24'h00_0000, s.vwidth};
				`LSFC_OFS_DUTY: next_s.rdat = {23'h00_0000, s.duty};
				`LSFC_OFS_SRAS: next_s.rdat = {27'h000_0000, s.sras};
				`LSFC_OFS_MODE: next_s.rdat = {27'h000_0000, s.mode};
				`LSFC_OFS_STATUS: next_s.rdat = {s.ovf, 3'h0, s.skew, s.easy,
					fmt, s.frame, s.raster, s.line, 3'h0};
				default: next_s.rdat = 32'h0000_0000;
			endcase
		if (wb_req && wb_we_i && wb_sel_i[0])
			unique case (wb_adr_i)
				`LSFC_OFS_HTOTAL: next_s.htotal = wb_dat_i[7:0];
				`LSFC_OFS_HDISP: next_s.hdisp = wb_dat_i[7:0];
				`LSFC_OFS_MAXRAS: next_s.maxras = wb_dat_i[4:0];
				`LSFC_OFS_CSTART: next_s.cstart = wb_dat_i[6:0];
				`LSFC_OFS_CEND: next_s.cend = wb_dat_i[4:0];
				`LSFC_OFS_SADDR: next_s.saddr[7:0] = wb_dat_i[7:0];
				`LSFC_OFS_CADDR: next_s.caddr[7:0] = wb_dat_i[7:0];
				`LSFC_OFS_VWIDTH: next_s.vwidth = wb_dat_i[7:0];
				`LSFC_OFS_DUTY: next_s.duty[7:0] = wb_dat_i[7:0];
				`LSFC_OFS_SRAS: next_s.sras = wb_dat_i[4:0];
				`LSFC_OFS_MODE: next_s.mode = wb_dat_i[4:0];
				default: next_s.ovf = s.ovf;
			endcase
		if (wb_req && wb_we_i && wb_sel_i[1])
			unique case (wb_adr_i)
				`LSFC_OFS_SADDR: next_s.saddr[15:8] = wb_dat_i[15:8];
				`LSFC_OFS_CADDR: next_s.caddr[15:8] = wb_dat_i[15:8];
				`LSFC_OFS_DUTY: next_s.duty[8] = wb_dat_i[8];
				default: next_s.ovf = s.ovf;
			endcase
		if (wb_req && wb_we_i && wb_sel_i[3] && wb_adr_i == `LSFC_OFS_STATUS
			&& wb_dat_i[31])
			next_s.ovf = 1'b0;
		// A word lost to a full FIFO outranks a clear in the same cycle
		if (push && !fifo_ready)
			next_s.ovf = 1'b1;

		if (tick)
		begin
			next_s.hcnt = line_end ? 8'h00 : s.hcnt + 8'h01;
			next_s.win_d = {s.win_d[1:0], disp_now};
			next_s.cur_d = {s.cur_d[1:0], cur_now};
			next_s.window = win_skew;
			next_s.cursor = cur_skew;
			next_s.latch = latch_now;
			if (latch_now)
			begin
				next_s.ma = {8'h00, s.ref_cnt};
				next_s.ref_cnt = s.ref_cnt + 8'h01;
			end
			else
				next_s.ma = addr_now;
		end
		if (line_end)
		begin
			next_s.line = s.line + 9'h001;
			if (fmt == FMT_GRAPH1 || s.raster >= maxras_eff)
			begin
				next_s.raster = 5'h00;
				next_s.row_base = s.row_base + {8'h00, vwid_eff};
			end
			else
				next_s.raster = s.raster + 5'h01;
		end
		if (frame_end)
		begin
			next_s.line = 9'h000;
			next_s.raster = (fmt == FMT_CHAR) ? sras_eff : 5'h00;
			next_s.row_base = s.saddr;
			next_s.frame = s.frame + 6'h01;
			next_s.skew = s.pins[7:6] == 2'h3 ? s.skew :
				{s.pins[7], s.pins[6] & !s.pins[7]};
			next_s.easy = s.pins[5];
			next_s.fpins = s.pins[4:0];
		end

		// Output stage: one byte per two clocks while the drivers accept
		if (pop)
		begin
			next_s.ob = fifo_data;
			next_s.ob_left = (fifo_data[17] || fifo_data[16]) ? 2'h2 : 2'h1;
			next_s.ob_phase = 1'b0;
		end
		else if (s.ob_left != 2'h0 && lcd_ready_i)
		begin
			next_s.ob_phase = !s.ob_phase;
			if (!s.ob_phase)
				next_s.lcd_data = (s.ob[17] && s.ob_left == 2'h2) ?
					s.ob[15:8] : s.ob[7:0];
			else
				next_s.ob_left = s.ob_left - 2'h1;
		end
		next_s.shift_clk = (s.ob_left != 2'h0) && lcd_ready_i && !s.ob_phase
			&& !pop;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.htotal <= `LSFC_RST_HTOTAL;
			s.hdisp <= `LSFC_RST_HDISP;
			s.maxras <= `LSFC_RST_MAXRAS;
			s.cstart <= `LSFC_RST_CSTART;
			s.cend <= `LSFC_RST_CEND;
			s.vwidth <= `LSFC_RST_HDISP;
			s.duty <= `LSFC_RST_DUTY;
		end
		else
			s <= next_s;
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.rdat;
	assign memory_address_out_o = s.ma;
	assign raster_address_out_o = s.raster;
	assign line_latch_clock_o = s.latch;
	assign display_window_timing_o = s.window;
	assign cursor_display_out_o = s.cursor;
	assign pixel_shift_clock_o = s.shift_clk;
	assign lcd_data_o = s.lcd_data;

	wb_ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single pulse");
	cursor_char_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && fmt != FMT_CHAR && s.skew == 2'h0 |=> !cursor_display_out_o)
		else $error("cursor shown outside character mode");
	refresh_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		line_latch_clock_o |-> memory_address_out_o[15:8] == 8'h00)
		else $error("refresh address out of range");
	easy_raster_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s.easy && line_end |=> raster_address_out_o <= `LSFC_EASY_MAXRAS)
		else $error("easy mode raster above fixed limit");
	graph1_raster_a: assert property (@(posedge clk_i) disable iff (rst_i)
		line_end && fmt == FMT_GRAPH1 |=> raster_address_out_o == 5'h00)
		else $error("graphic 1 raster not zero");
	start_raster_a: assert property (@(posedge clk_i) disable iff (rst_i)
		frame_end && fmt == FMT_CHAR |=> raster_address_out_o == $past(sras_eff))
		else $error("frame did not start at start raster");
	or_merge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		push && fmt == FMT_CHAR && !mode_eff[`LSFC_MODE_AT] |->
		push_data[7:0] == (s.md_s3[7:0] | s.md_s3[15:8]))
		else $error("OR byte wrong");
	wide_twice_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pop && fifo_data[16] |=> s.ob_left == 2'h2)
		else $error("wide byte not doubled");
	skew_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && s.skew == 2'h1 |=> display_window_timing_o == $past(s.win_d[0]))
		else $error("one character skew wrong");
endmodule : lsfc_top

// *** src/lsfc_defines.svh ***
// Constants of the LCD screen format controller
// Behaviour
// - Cursor appears only in character mode, never in either graphic mode.
// - Effective mode is the OR of mode pins and mode register bits.
// - Character mode fetches bytes, rendered via character generator with attributes.
// - Graphic 1 shows 16-bit words directly; no attributes, no wide display.
// - Graphic 2 fetches 16-bit words, repeating each address for max raster + 1 rasters.
// - Row addresses advance by the virtual width; start address moves the view.
// - Character mode frames begin at the programmed start raster.
// - Wide display outputs each character byte twice, character mode only.
// - Attribute display uses mode bit 0 or attribute pin, character mode only.
// - Attribute word: code bits 7-0, bits 11-15 reverse, cursor, blink, blanks.
// - OR display merges low and high data bytes into one byte.
// - OR display applies no attribute effects.
// - While line latch clock is high, sixteen refresh addresses 00-FF are output.
// - Skew delays cursor, window, shift clock and data sampling by character times.
// - Skew pins: 00 none, low only one, high only two; both high forbidden.
// - Easy mode pin forces fixed format values, ignoring programmed ones.
// - Easy values: raster 7, cursor 6-7, width=displayed, duty 99/199, start 0.
// - Cursor blink bits: steady, off, every 32 frames, every 64 frames.
`ifndef LSFC_DEFINES_SVH
`define LSFC_DEFINES_SVH
`define LSFC_OFS_HTOTAL 8'h00
`define LSFC_OFS_HDISP 8'h04
`define LSFC_OFS_MAXRAS 8'h08
`define LSFC_OFS_CSTART 8'h0C
`define LSFC_OFS_CEND 8'h10
`define LSFC_OFS_SADDR 8'h14
`define LSFC_OFS_CADDR 8'h18
`define LSFC_OFS_VWIDTH 8'h1C
`define LSFC_OFS_DUTY 8'h20
`define LSFC_OFS_SRAS 8'h24
`define LSFC_OFS_MODE 8'h28
`define LSFC_OFS_STATUS 8'h2C
`define LSFC_RST_HTOTAL 8'h63
`define LSFC_RST_HDISP 8'h50
`define LSFC_RST_MAXRAS 5'h07
`define LSFC_RST_CSTART 7'h06
`define LSFC_RST_CEND 5'h07
`define LSFC_RST_DUTY 9'h0C7
`define LSFC_MODE_AT 0
`define LSFC_MODE_BLE 1
`define LSFC_MODE_WIDE 2
`define LSFC_MODE_GC 3
`define LSFC_MODE_OFF 4
`define LSFC_ATR_REV 11
`define LSFC_ATR_CUR 12
`define LSFC_ATR_BLINK 13
`define LSFC_ATR_WHITE 14
`define LSFC_ATR_BLACK 15
`define LSFC_BLINK_ON 2'h0
`define LSFC_BLINK_OFF 2'h1
`define LSFC_BLINK_32 2'h2
`define LSFC_BLINK_64 2'h3
`define LSFC_REFRESH_PER_LINE 9'h010
`define LSFC_EASY_MAXRAS 5'h07
`define LSFC_EASY_CSTART 5'h06
`define LSFC_EASY_CEND 5'h07
`define LSFC_EASY_DUTY_DUAL 9'h063
`define LSFC_EASY_DUTY_SINGLE 9'h0C7
`define LSFC_FIFO_DEPTH 16
`define LSFC_FIFO_WIDTH 18
`endif

// *** src/lsfc_pkg.sv ***
// Types of the LCD screen format controller
package lsfc_pkg;
	typedef enum logic [1:0] {FMT_CHAR, FMT_GRAPH1, FMT_GRAPH2} lsfc_fmt_t;
	typedef struct packed {
		logic [2:0] ck_sync;
		logic ck_lvl;
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
		logic [7:0] pin_s3;
		logic [7:0] pins;
		logic [15:0] md_s1;
		logic [15:0] md_s2;
		logic [15:0] md_s3;
		logic [7:0] htotal;
		logic [7:0] hdisp;
		logic [4:0] maxras;
		logic [6:0] cstart;
		logic [4:0] cend;
		logic [15:0] saddr;
		logic [15:0] caddr;
		logic [7:0] vwidth;
		logic [8:0] duty;
		logic [4:0] sras;
		logic [4:0] mode;
		logic ovf;
		logic ack;
		logic [31:0] rdat;
		logic [7:0] hcnt;
		logic [4:0] raster;
		logic [8:0] line;
		logic [15:0] row_base;
		logic [5:0] frame;
		logic [7:0] ref_cnt;
		logic [1:0] skew;
		logic easy;
		logic [4:0] fpins;
		logic [15:0] ma;
		logic latch;
		logic [2:0] win_d;
		logic [2:0] cur_d;
		logic window;
		logic cursor;
		logic [17:0] ob;
		logic [1:0] ob_left;
		logic ob_phase;
		logic [7:0] lcd_data;
		logic shift_clk;
	} lsfc_state_t;
endpackage : lsfc_pkg

// *** bench/lsfc_partner.sv ***
// Display memory and LCD driver model for the format controller bench
`timescale 1ns/1ns

module lsfc_partner (
	input wire logic clk_i,
	input wire logic [15:0] fill_i,
	input wire logic stall_i,
	input wire logic latch_i,
	input wire logic shift_i,
	input wire logic [7:0] data_i,
	output logic [15:0] mem_data_o,
	output logic ready_o,
	output logic [7:0] last_o,
	output logic [7:0] prev_o,
	output logic [7:0] bytes_o
);
	logic [7:0] cnt = 8'h00;
	logic latch_q = 1'b0;
	// No wait states; every cell holds the fill word, so bytes are predictable
	assign mem_data_o = fill_i;
	assign ready_o = !stall_i;
	always @(posedge clk_i)
	begin
		if (shift_i)
		begin
			prev_o <= last_o;
			last_o <= data_i;
		end
		// Bytes counted between line latches
		if (latch_i && !latch_q)
		begin
			bytes_o <= cnt;
			cnt <= {7'h00, shift_i};
		end
		else
			cnt <= cnt + {7'h00, shift_i};
		latch_q <= latch_i;
	end
endmodule : lsfc_partner

// *** bench/lcd_screen_format_control_bench.sv ***
// Self-checking bench of the LCD screen format controller
`timescale 1ns/1ns
`include "lsfc_defines.svh"

module lcd_screen_format_control_bench;
	import lsfc_pkg::*;
	localparam int LIMIT = 95000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic chk = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] dat, got, st, mask;
	logic ack, latch, win, cur, shift, ready;
	logic graph = 1'b0;
	logic wide = 1'b0;
	logic attr = 1'b0;
	logic easy = 1'b0;
	logic sk_lo = 1'b0;
	logic sk_hi = 1'b0;
	logic stall = 1'b0;
	logic [15:0] fill = 16'h0F30;
	logic [15:0] md, ma;
	logic [4:0] ra;
	logic [7:0] lcd, last, prev, nbytes;
	logic latch_q = 1'b0;
	logic win_q = 1'b0;
	logic [15:0] ma_q = 16'h0000;
	logic seen0, seen1, cur_seen;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int t_latch = 0;
	int steps = 0;
	int bad = 0;
	int delta = 0;
	int d0 = 0;
	logic [15:0] atr_w [5] = '{16'h0730, 16'h0830, 16'h8030, 16'h4030,
		16'h1030};
	logic [7:0] atr_e [5] = '{8'h30, 8'hCF, 8'hFF, 8'h00, 8'hCF};
	logic [1:0] sk_p [3] = '{2'h1, 2'h2, 2'h3};
	logic [1:0] sk_s [3] = '{2'h1, 2'h2, 2'h2};
	int sk_d [3] = '{20, 40, 40};

	always #2 clk_i = ~clk_i;
	always #40 chk = ~chk;

	lsfc_top i_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(wdat),
		.wb_dat_o(dat),
		.wb_ack_o(ack),
		.char_clk_i(chk),
		.dual_screen_i(1'b0),
		.graphic_select_i(graph),
		.large_screen_select_i(1'b0),
		.wide_select_i(wide),
		.attribute_or_select_i(attr),
		.easy_mode_i(easy),
		.skew_select_low_i(sk_lo),
		.skew_select_high_i(sk_hi),
		.memory_data_in_i(md),
		.memory_address_out_o(ma),
		.raster_address_out_o(ra),
		.line_latch_clock_o(latch),
		.display_window_timing_o(win),
		.cursor_display_out_o(cur),
		.pixel_shift_clock_o(shift),
		.lcd_data_o(lcd),
		.lcd_ready_i(ready)
	);

	lsfc_partner i_partner (
		.clk_i(clk_i),
		.fill_i(fill),
		.stall_i(stall),
		.latch_i(latch),
		.shift_i(shift),
		.data_i(lcd),
		.mem_data_o(md),
		.ready_o(ready),
		.last_o(last),
		.prev_o(prev),
		.bytes_o(nbytes)
	);

	task automatic conclude;
		$display("Checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		got = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, 4'hF, d);
	endtask : wr

	task automatic rd(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 4'hF, 32'h0000_0000);
		check(what, got, exp);
	endtask : rd

	task automatic status;
		bus(1'b0, `LSFC_OFS_STATUS, 4'hF, 32'h0000_0000);
		st = got;
	endtask : status

	// Bytes of a line may still leave the FIFO just after the latch
	task automatic lines(input int n);
		repeat (n) @(posedge latch);
		repeat (30) @(posedge clk_i);
	endtask : lines

	task automatic rows;
		seen0 = 1'b0;
		seen1 = 1'b0;
		bad = 0;
		lines(5);
		check("first row", seen0, 32'h1);
		check("second row", seen1, 32'h1);
		check("stray row", bad, 32'h0);
	endtask : rows

	always @(posedge clk_i)
	begin
		cycles++;
		mask |= 32'h0000_0001 << ra;
		cur_seen |= cur;
		// Last display address of the line names its row
		if (latch && !latch_q)
		begin
			t_latch = cycles;
			steps = 0;
			if (ma_q == 16'h0103)
				seen0 = 1'b1;
			else if (ma_q == 16'h010D)
				seen1 = 1'b1;
			else
				bad++;
		end
		if (latch && latch_q && ma !== ma_q)
		begin
			check("refresh addr", ma,
				{8'h00, ma_q[7:0] + 8'h01});
			steps++;
		end
		if (!latch && latch_q)
			check("refresh count", steps, 32'h0000_000F);
		if (!win && win_q)
			delta = (cycles - t_latch) % 480;
		latch_q = latch;
		win_q = win;
		ma_q = ma;
		if (cycles == LIMIT)
		begin
			errors++;
			conclude();
		end
	end

	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("max raster", `LSFC_OFS_MAXRAS, 32'h0000_0007);
		rd("cursor end", `LSFC_OFS_CEND, 32'h0000_0007);
		rd("duty", `LSFC_OFS_DUTY, 32'h0000_00C7);
		rd("unmapped", 8'h30, 32'h0000_0000);
		$display("test reset done");
		// Short lines and frames keep the run brief
		wr(`LSFC_OFS_HTOTAL, 32'h0000_0017);
		wr(`LSFC_OFS_HDISP, 32'h0000_0004);
		wr(`LSFC_OFS_DUTY, 32'h0000_0003);
		wr(`LSFC_OFS_MAXRAS, 32'h0000_0001);
		wr(`LSFC_OFS_VWIDTH, 32'h0000_000A);
		wr(`LSFC_OFS_SADDR, 32'h0000_0100);
		wr(`LSFC_OFS_CSTART, 32'h0000_0000);
		wr(`LSFC_OFS_CEND, 32'h0000_0001);
		wr(`LSFC_OFS_CADDR, 32'h0000_0101);
		lines(6);
		mask = 32'h0000_0000;
		cur_seen = 1'b0;
		rows();
		check("cursor", cur_seen, 32'h1);
		check("bytes", nbytes, 32'h4);
		check("or byte", last, 32'h3F);
		check("rasters", mask, 32'h3);
		status();
		check("format", st[24:23], FMT_CHAR);
		d0 = delta;
		wr(`LSFC_OFS_CSTART, 32'h0000_0020);
		lines(4);
		cur_seen = 1'b0;
		lines(4);
		check("cursor off", cur_seen, 32'h0);
		wr(`LSFC_OFS_CSTART, 32'h0000_0000);
		wr(`LSFC_OFS_MAXRAS, 32'h0000_0003);
		wr(`LSFC_OFS_DUTY, 32'h0000_0002);
		wr(`LSFC_OFS_SRAS, 32'h0000_0001);
		lines(4);
		mask = 32'h0000_0000;
		lines(6);
		check("start raster", mask, 32'hE);
		$display("test character done");
		wr(`LSFC_OFS_MODE, 32'h0000_0001);
		for (int i = 0; i < 5; i++)
		begin
			fill <= atr_w[i];
			lines(4);
			check("attribute", last, atr_e[i]);
		end
		wr(`LSFC_OFS_MODE, 32'h0000_0000);
		fill <= 16'h0F30;
		wide <= 1'b1;
		lines(6);
		check("wide bytes", nbytes, 32'h8);
		$display("test attribute and wide done");
		graph <= 1'b1;
		fill <= 16'hA55A;
		lines(5);
		cur_seen = 1'b0;
		mask = 32'h0000_0000;
		lines(6);
		check("no cursor", cur_seen, 32'h0);
		check("graphic rasters", mask, 32'h7);
		check("word bytes", nbytes, 32'h8);
		check("high byte", prev, 32'hA5);
		check("low byte", last, 32'h5A);
		status();
		check("format", st[24:23], FMT_GRAPH2);
		wr(`LSFC_OFS_MAXRAS, 32'h0000_0001);
		wr(`LSFC_OFS_DUTY, 32'h0000_0003);
		wr(`LSFC_OFS_SRAS, 32'h0000_0000);
		lines(5);
		rows();
		attr <= 1'b1;
		fill <= 16'h0830;
		lines(6);
		check("plain high", prev, 32'h08);
		check("plain low", last, 32'h30);
		check("word bytes", nbytes, 32'h8);
		status();
		check("format", st[24:23], FMT_GRAPH1);
		$display("test graphic done");
		graph <= 1'b0;
		attr <= 1'b0;
		wide <= 1'b0;
		fill <= 16'h0F30;
		// Last entry drives both pins high on purpose
		for (int i = 0; i < 3; i++)
		begin
			{sk_hi, sk_lo} <= sk_p[i];
			lines(6);
			status();
			check("skew", st[27:26], sk_s[i]);
			check("delay", (delta + 480 - d0) % 480,
				sk_d[i]);
		end
		{sk_hi, sk_lo} <= 2'h0;
		$display("test skew done");
		stall <= 1'b1;
		lines(6);
		status();
		check("overflow", st[31], 32'h1);
		stall <= 1'b0;
		lines(2);
		bus(1'b1, `LSFC_OFS_STATUS, 4'h8, 32'h8000_0000);
		status();
		check("overflow clear", st[31], 32'h0);
		lines(2);
		check("drained bytes", nbytes, 32'h4);
		$display("test buffer done");
		// Display off blanks the window, so no byte reaches the drivers
		wr(`LSFC_OFS_MODE, 32'h0000_0010);
		lines(3);
		check("display off", nbytes, 32'h0);
		wr(`LSFC_OFS_MODE, 32'h0000_0008);
		easy <= 1'b1;
		lines(6);
		status();
		check("easy", st[25], 32'h1);
		check("easy format", st[24:23], FMT_CHAR);
		mask = 32'h0000_0000;
		lines(9);
		check("easy rasters", mask, 32'hFF);
		$display("test easy done");
		conclude();
	end
endmodule : lcd_screen_format_control_bench
